// ---- verilog/aotcm_pkg.sv ----
// Constants, types and helpers shared by the trim and sequencing block.
// Assumes a single 40 MHz system clock and a synchronous register port.
`default_nettype none
package aotcm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [3:0] ADDR_RESULT = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h1;
	localparam logic [3:0] ADDR_TIMER = 4'h2;
	localparam logic [3:0] ADDR_CFG3 = 4'h3;
	localparam logic [3:0] ADDR_OFFSET = 4'h9;
	localparam logic [3:0] ADDR_GAIN = 4'ha;

	////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int CFG3_GAIN_ON_BIT = 0;
	localparam int CFG3_OFF_ON_BIT = 1;
	localparam int CFG3_SEQ_LSB = 4;
	localparam int CTRL_STATE_LSB = 0;
	localparam int CTRL_SCAN_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// Values after reset; a gain code of 0x800000 is a multiplier of one.
	localparam logic [23:0] RST_CFG3 = 24'h000000;
	localparam logic [23:0] RST_CTRL = 24'h000000;
	localparam logic [23:0] RST_TIMER = 24'h000000;
	localparam logic [23:0] RST_OFFSET = 24'h000000;
	localparam logic [23:0] RST_GAIN = 24'h800000;

	////////////////////////////////////////////////////////////////////////
	// Counts of cycles and of modulator ticks, and the gain code's fraction bits.
	localparam logic [7:0] MOD_TICK_DIV = 8'h04;
	localparam logic [4:0] GAIN_TRIM_LATENCY = 5'h17;
	localparam int GAIN_FRAC_BITS = 23;

	////////////////////////////////////////////////////////////////////////
	// Converter state and sequencing codes.
	localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] MODE_STANDBY = 2'h2;
	localparam logic [1:0] MODE_CONVERT = 2'h3;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_CONV = 3'b010,
		SEQ_WAIT = 3'b100
	} aotcm_seq_t;

	////////////////////////////////////////////////////////////////////////
	// Clamps a wide signed value to the 24-bit signed output range.
	function automatic logic [23:0] sat24(input logic signed [48:0] v);
		logic signed [48:0] hi;
		logic signed [48:0] lo;
		hi = 49'sh0_0000_007f_ffff;
		lo = -49'sh0_0000_0080_0000;
		if (v > hi) begin
			sat24 = 24'h7fffff;
		end else if (v < lo) begin
			sat24 = 24'h800000;
		end else begin
			sat24 = v[23:0];
		end
	endfunction

endpackage
`default_nettype wire

// ---- verilog/aotcm_gmul_if.sv ----
// Carrier between the trim control logic and the gain multiplier.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
`default_nettype none
interface aotcm_gmul_if;
	logic mod_tick;
	logic start;
	logic signed [24:0] operand;
	logic [23:0] gain;
	logic done;
	logic signed [48:0] product;

	modport ctl (output mod_tick, output start, output operand, output gain,
		input done, input product);
	modport mul (input mod_tick, input start, input operand, input gain,
		output done, output product);
endinterface
`default_nettype wire

// ---- verilog/aotcm_gain_mult.sv ----
// Add-and-shift gain multiplier stepped on the modulator digital clock enable.
// Assumes a new start never comes while a product is still being formed.
`timescale 1ns/100ps
`default_nettype none
module aotcm_gain_mult (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Link to the control logic.
	aotcm_gmul_if.mul gm
);
	logic signed [48:0] acc_q, acc_d, opnd_q, opnd_d, opnd_ext;
	logic [23:0] gain_q, gain_d;
	logic [4:0] idx_q, idx_d;
	logic busy_q, busy_d, done_q, done_d;
	logic [4:0] ticks_q;

	////////////////////////////////////////////////////////////////////////
	// Bit 0 is added at the start; bits 1 to 23 take one tick each.
	always_comb begin
		opnd_ext = {{24{gm.operand[24]}}, gm.operand};
		acc_d = acc_q;
		opnd_d = opnd_q;
		gain_d = gain_q;
		idx_d = idx_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (gm.start) begin
			opnd_d = opnd_ext;
			gain_d = gm.gain;
			acc_d = gm.gain[0] ? opnd_ext : '0;
			idx_d = 5'h01;
			busy_d = 1'b1;
		end else if (busy_q && gm.mod_tick) begin
			acc_d = acc_q + (gain_q[idx_q] ? (opnd_q <<< idx_q) : '0);
			if (idx_q == aotcm_pkg::GAIN_TRIM_LATENCY) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end else begin
				idx_d = idx_q + 5'h01;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_q <= '0;
			opnd_q <= '0;
			gain_q <= '0;
			idx_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			opnd_q <= opnd_d;
			gain_q <= gain_d;
			idx_q <= idx_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign gm.done = done_q;
	assign gm.product = acc_q;

	////////////////////////////////////////////////////////////////////////
	// Independent count of ticks since the start, read only by the check.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ticks_q <= '0;
		end else if (gm.start) begin
			ticks_q <= '0;
		end else if (busy_q && gm.mod_tick) begin
			ticks_q <= ticks_q + 5'h01;
		end
	end

	property p_gain_latency;
		@(posedge i_clk) disable iff (i_rst)
		done_q |-> ticks_q == aotcm_pkg::GAIN_TRIM_LATENCY;
	endproperty
	a_gain_latency: assert property (p_gain_latency)
		else $error("gain product not ready after 23 modulator ticks");

endmodule
`default_nettype wire

// ---- verilog/aotcm_top.sv ----
// Output trim (offset add, gain multiply) and conversion sequencing.
// Assumes raw codes arrive as one-cycle strobes spaced wider than 24 modulator ticks.
`timescale 1ns/100ps
`default_nettype none
module aotcm_top (
	// Clock and reset.
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	// Register port.
	input wire logic [3:0] I_REG_ADDR,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [23:0] I_REG_WDATA,
	output logic [23:0] O_REG_RDATA,
	output logic O_REG_RVALID,
	// Modulator side.
	input wire logic I_RAW_VALID,
	input wire logic [23:0] I_RAW_CODE,
	input wire logic I_RAW_LAST,
	output logic O_CONV_RUN,
	output logic O_DRDY
);
	aotcm_gmul_if gm ();

	logic [23:0] cfg3_q, cfg3_d, timer_q, timer_d, offset_q, offset_d, gain_q, gain_d;
	logic [1:0] adc_mode_q, adc_mode_d;
	logic scan_en_q, scan_en_d;
	logic [23:0] result_q, result_d, rdata_q, rdata_d;
	logic drdy_q, drdy_d, rvalid_q, rvalid_d, run_q, run_d;
	aotcm_pkg::aotcm_seq_t seq_q, seq_d;
	logic [23:0] wait_q, wait_d;
	logic [7:0] div_q, div_d;
	logic mod_tick_q, mod_tick_d;
	logic gain_on, off_on;
	logic [1:0] seq_sel;
	logic signed [24:0] sum;
	logic signed [48:0] scaled;
	logic wr_ctrl;

	assign gain_on = cfg3_q[aotcm_pkg::CFG3_GAIN_ON_BIT];
	assign off_on = cfg3_q[aotcm_pkg::CFG3_OFF_ON_BIT];
	assign seq_sel = cfg3_q[aotcm_pkg::CFG3_SEQ_LSB +: 2];
	assign wr_ctrl = I_REG_WR && (I_REG_ADDR == aotcm_pkg::ADDR_CTRL);

	////////////////////////////////////////////////////////////////////////
	// Modulator digital clock enable.
	always_comb begin
		mod_tick_d = 1'b0;
		div_d = div_q + 8'h01;
		if (div_q == aotcm_pkg::MOD_TICK_DIV - 8'h01) begin
			div_d = '0;
			mod_tick_d = 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			div_q <= '0;
			mod_tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			mod_tick_q <= mod_tick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file and read port.
	always_comb begin
		cfg3_d = cfg3_q;
		timer_d = timer_q;
		offset_d = offset_q;
		gain_d = gain_q;
		rdata_d = rdata_q;
		rvalid_d = I_REG_RD;
		if (I_REG_WR) begin
			if (I_REG_ADDR == aotcm_pkg::ADDR_CFG3) begin
				cfg3_d = I_REG_WDATA;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_TIMER) begin
				timer_d = I_REG_WDATA;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_OFFSET) begin
				offset_d = I_REG_WDATA;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_GAIN) begin
				gain_d = I_REG_WDATA;
			end
		end
		if (I_REG_RD) begin
			if (I_REG_ADDR == aotcm_pkg::ADDR_RESULT) begin
				rdata_d = result_q;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_CTRL) begin
				rdata_d = {21'h0, scan_en_q, adc_mode_q};
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_TIMER) begin
				rdata_d = timer_q;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_CFG3) begin
				rdata_d = cfg3_q;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_OFFSET) begin
				rdata_d = offset_q;
			end else if (I_REG_ADDR == aotcm_pkg::ADDR_GAIN) begin
				rdata_d = gain_q;
			end else begin
				rdata_d = 24'h000000;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cfg3_q <= aotcm_pkg::RST_CFG3;
			timer_q <= aotcm_pkg::RST_TIMER;
			offset_q <= aotcm_pkg::RST_OFFSET;
			gain_q <= aotcm_pkg::RST_GAIN;
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end else begin
			cfg3_q <= cfg3_d;
			timer_q <= timer_d;
			offset_q <= offset_d;
			gain_q <= gain_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trim datapath. The sum keeps a guard bit and the product keeps all of
	// its bits, so clamping happens only on the final value.
	assign sum = $signed({I_RAW_CODE[23], I_RAW_CODE})
		+ (off_on ? $signed({offset_q[23], offset_q}) : 25'sh0);
	assign scaled = gm.product >>> aotcm_pkg::GAIN_FRAC_BITS;

	assign gm.mod_tick = mod_tick_q;
	assign gm.start = I_RAW_VALID && gain_on;
	assign gm.operand = sum;
	assign gm.gain = gain_q;

	aotcm_gain_mult u_mult (
		.i_clk(I_CLK_SYS),
		.i_rst(I_SYS_RST),
		.gm(gm)
	);

	// The held result moves only when a finished value arrives.
	always_comb begin
		result_d = result_q;
		drdy_d = 1'b0;
		if (gm.done) begin
			result_d = aotcm_pkg::sat24(scaled);
			drdy_d = 1'b1;
		end
		if (I_RAW_VALID && !gain_on) begin
			result_d = aotcm_pkg::sat24({{24{sum[24]}}, sum});
			drdy_d = 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			result_q <= '0;
			drdy_q <= 1'b0;
		end else begin
			result_q <= result_d;
			drdy_q <= drdy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer. It never waits on the multiplier.
	always_comb begin
		seq_d = seq_q;
		wait_d = wait_q;
		adc_mode_d = adc_mode_q;
		scan_en_d = scan_en_q;
		if (wr_ctrl) begin
			adc_mode_d = I_REG_WDATA[aotcm_pkg::CTRL_STATE_LSB +: 2];
			scan_en_d = I_REG_WDATA[aotcm_pkg::CTRL_SCAN_BIT];
		end
		case (seq_q)
			aotcm_pkg::SEQ_IDLE: begin
				if (adc_mode_q == aotcm_pkg::MODE_CONVERT) begin
					seq_d = aotcm_pkg::SEQ_CONV;
				end
			end
			aotcm_pkg::SEQ_CONV: begin
				if (adc_mode_q != aotcm_pkg::MODE_CONVERT) begin
					seq_d = aotcm_pkg::SEQ_IDLE;
				end else if (I_RAW_VALID && (!scan_en_q || I_RAW_LAST)) begin
					if (seq_sel == aotcm_pkg::MODE_CONVERT) begin
						if (scan_en_q) begin
							seq_d = aotcm_pkg::SEQ_WAIT;
							wait_d = '0;
						end
					end else begin
						seq_d = aotcm_pkg::SEQ_IDLE;
						adc_mode_d = seq_sel[1] ? aotcm_pkg::MODE_STANDBY
							: aotcm_pkg::MODE_SHUTDOWN;
					end
				end
			end
			aotcm_pkg::SEQ_WAIT: begin
				if (adc_mode_q != aotcm_pkg::MODE_CONVERT) begin
					seq_d = aotcm_pkg::SEQ_IDLE;
				end else if (mod_tick_q) begin
					if (wait_q >= timer_q) begin
						seq_d = aotcm_pkg::SEQ_CONV;
					end else begin
						wait_d = wait_q + 24'h000001;
					end
				end
			end
			default: begin
				seq_d = aotcm_pkg::SEQ_IDLE;
			end
		endcase
		run_d = (seq_d == aotcm_pkg::SEQ_CONV);
	end

	always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			seq_q <= aotcm_pkg::SEQ_IDLE;
			wait_q <= '0;
			adc_mode_q <= aotcm_pkg::RST_CTRL[1:0];
			scan_en_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			wait_q <= wait_d;
			adc_mode_q <= adc_mode_d;
			scan_en_q <= scan_en_d;
			run_q <= run_d;
		end
	end

	assign O_REG_RDATA = rdata_q;
	assign O_REG_RVALID = rvalid_q;
	assign O_CONV_RUN = run_q;
	assign O_DRDY = drdy_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_SYS_RST);

	sequence s_mux_end;
		seq_q == aotcm_pkg::SEQ_CONV && adc_mode_q == aotcm_pkg::MODE_CONVERT
			&& I_RAW_VALID && !scan_en_q && !wr_ctrl;
	endsequence

	property p_off_add;
		(I_RAW_VALID && !gain_on && off_on)
			|=> result_q == aotcm_pkg::sat24($signed({{25{$past(I_RAW_CODE[23])}},
			$past(I_RAW_CODE)}) + $signed({{25{$past(offset_q[23])}}, $past(offset_q)}));
	endproperty
	a_off_add: assert property (p_off_add)
		else $error("offset sum not loaded into result");

	property p_off_skip;
		(I_RAW_VALID && !gain_on && !off_on) |=> result_q == $past(I_RAW_CODE);
	endproperty
	a_off_skip: assert property (p_off_skip)
		else $error("disabled offset still applied");

	property p_direct_drdy;
		(I_RAW_VALID && !gain_on) |=> O_DRDY;
	endproperty
	a_direct_drdy: assert property (p_direct_drdy)
		else $error("offset-only result not ready on the next cycle");

	property p_gain_no_drdy;
		(I_RAW_VALID && gain_on) |=> (!O_DRDY) [*3];
	endproperty
	a_gain_no_drdy: assert property (p_gain_no_drdy)
		else $error("gain result came before its latency");

	property p_hold;
		$changed(result_q) |-> O_DRDY;
	endproperty
	a_hold: assert property (p_hold)
		else $error("result changed without a data ready");

	property p_oneshot_down;
		(s_mux_end and seq_sel[1] == 1'b0) |=> adc_mode_q == aotcm_pkg::MODE_SHUTDOWN
			##0 !O_CONV_RUN;
	endproperty
	a_oneshot_down: assert property (p_oneshot_down)
		else $error("one-shot did not return to shutdown");

	property p_oneshot_standby;
		(s_mux_end and seq_sel == aotcm_pkg::MODE_STANDBY)
			|=> adc_mode_q == aotcm_pkg::MODE_STANDBY;
	endproperty
	a_oneshot_standby: assert property (p_oneshot_standby)
		else $error("one-shot did not return to standby");

	property p_continuous;
		(s_mux_end and seq_sel == aotcm_pkg::MODE_CONVERT)
			|=> adc_mode_q == aotcm_pkg::MODE_CONVERT && O_CONV_RUN;
	endproperty
	a_continuous: assert property (p_continuous)
		else $error("continuous conversion stopped");

	property p_scan_gap;
		(seq_q == aotcm_pkg::SEQ_WAIT) |-> !O_CONV_RUN && adc_mode_q == aotcm_pkg::MODE_CONVERT;
	endproperty
	a_scan_gap: assert property (p_scan_gap)
		else $error("converter ran during the scan delay");

endmodule
`default_nettype wire

// ---- sim/aotcm_mod_model.sv ----
// Modulator model: hands one raw code to the trim block per bench request.
// Assumes the bench raises a request off the rising edge and holds it until the strobe.
`timescale 1ns/100ps
`default_nettype none
module aotcm_mod_model (
	// Clock.
	input wire logic i_clk,
	// Requests from the bench.
	input wire logic i_req,
	input wire logic [23:0] i_code,
	input wire logic i_last,
	// Converter side.
	input wire logic i_conv_run,
	output logic o_valid,
	output logic [23:0] o_code,
	output logic o_last
);
	initial begin
		o_valid = 1'b0;
		o_code = 24'h000000;
		o_last = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Outside a strobe the data lines toggle, so a stale code never looks valid.
	// A code is only delivered while the converter is told to run.
	always @(negedge i_clk) begin
		o_valid <= 1'b0;
		o_code <= ~o_code;
		o_last <= ~o_last;
		if (i_req && i_conv_run && !o_valid) begin
			o_valid <= 1'b1;
			o_code <= i_code;
			o_last <= i_last;
		end
	end
endmodule
`default_nettype wire

// ---- sim/adc_output_trim_and_conv_mode_test.sv ----
// Self-checking bench for the trim and sequencing block.
// Assumes the modulator model beside it and a 40 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module adc_output_trim_and_conv_mode_test;
	logic clk, rst, we, re, rvalid, req, raw_valid, raw_last, last, run_o, drdy;
	logic [3:0] addr;
	logic [23:0] wdata, rdata, raw_code, code, v, raw, off, gn, pexp;
	logic oo, go, run;
	int err_count, n_checks, seed, i, k, lat;
	logic [3:0] ra [6] = '{4'h3, 4'h1, 4'h2, 4'h9, 4'ha, 4'h5};
	logic [23:0] rv [6] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h800000, 24'h0};
	logic [1:0] sq [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
	logic [1:0] st [6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h2, 2'h0};
	logic sc [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic ls [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

	aotcm_top u_aotcm_top (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_REG_ADDR(addr),
		.I_REG_WR(we), .I_REG_RD(re), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
		.O_REG_RVALID(rvalid), .I_RAW_VALID(raw_valid), .I_RAW_CODE(raw_code),
		.I_RAW_LAST(raw_last), .O_CONV_RUN(run_o), .O_DRDY(drdy));
	aotcm_mod_model u_aotcm_mod_model (.i_clk(clk), .i_req(req), .i_code(code),
		.i_last(last), .i_conv_run(run_o), .o_valid(raw_valid), .o_code(raw_code),
		.o_last(raw_last));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Expected result: offset add, then gain as code over 2^23, then clamp.
	function automatic logic [23:0] exp_trim(input logic [23:0] r, input logic [23:0] o,
		input logic [23:0] g, input logic on_o, input logic on_g);
		logic signed [48:0] s;
		s = $signed({{25{r[23]}}, r});
		if (on_o) begin
			s = s + $signed({{25{o[23]}}, o});
		end
		if (on_g) begin
			s = (s * $signed({25'h0, g})) >>> 23;
		end
		if (s > 49'sh7fffff) begin
			return 24'h7fffff;
		end else if (s < -49'sh800000) begin
			return 24'h800000;
		end
		return s[23:0];
	endfunction

	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		@(negedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(negedge clk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [23:0] d);
		@(negedge clk);
		addr <= a;
		re <= 1'b1;
		@(negedge clk);
		re <= 1'b0;
		check({23'h0, rvalid}, 24'h1, "read valid");
		d = rdata;
	endtask

	// Requests one raw code, then counts edges from its strobe's edge, counted as
	// one, to the edge that loads the result; outputs are looked at on falling edges.
	task automatic convert(input logic [23:0] c, input logic l, output int n,
		output logic r);
		int w;
		@(negedge clk);
		req <= 1'b1;
		code <= c;
		last <= l;
		w = 0;
		while (raw_valid !== 1'b1 && w < 50) begin
			@(posedge clk);
			w++;
		end
		n = 0;
		do begin
			@(negedge clk);
			req <= 1'b0;
			n++;
		end while (drdy !== 1'b1 && n < 150);
		r = run_o;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 30000);
		err_count++;
		test_done();
	end

	initial begin
		seed = 41;
		err_count = 0;
		n_checks = 0;
		rst = 1'b1;
		{we, re, req, last} = 4'h0;
		addr = 4'h0;
		wdata = 24'h0;
		code = 24'h0;
		pexp = 24'h0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst <= 1'b0;
		// Reset values, with an unmapped write that must leave no trace.
		wr(4'h5, 24'habcdef);
		for (i = 0; i < 6; i++) begin
			rd(ra[i], v);
			check(v, rv[i], "reset value");
		end
		wr(aotcm_pkg::ADDR_CTRL, 24'h000003);
		rd(aotcm_pkg::ADDR_CTRL, v);
		check({v[2:0], run_o}, 4'h7, "continuous start");
		// Trim data path over all enable pairs, corner codes among random ones.
		for (i = 0; i < 16; i++) begin
			oo = i[1];
			go = i[0];
			raw = $random(seed);
			off = $random(seed);
			gn = $random(seed);
			if (i == 3) begin
				raw = 24'h7fffff;
				off = 24'h7fffff;
				gn = 24'h400000;
			end
			if (i == 7) begin
				raw = 24'h7fff00;
				off = 24'h000200;
			end
			if (i == 11) begin
				raw = 24'h800000;
				off = 24'hffffff;
				gn = 24'h800000;
			end
			wr(aotcm_pkg::ADDR_CFG3, {18'h0, 2'h3, 2'h0, oo, go});
			wr(aotcm_pkg::ADDR_OFFSET, off);
			wr(aotcm_pkg::ADDR_GAIN, gn);
			wr(aotcm_pkg::ADDR_RESULT, ~pexp);
			rd(aotcm_pkg::ADDR_GAIN, v);
			check(v, gn, "gain readback");
			if (i > 0) begin
				rd(aotcm_pkg::ADDR_RESULT, v);
				check(v, pexp, "held result");
			end
			convert(raw, 1'b0, lat, run);
			if (go) begin
				check({23'h0, lat >= 91 && lat <= 94}, 24'h1, "gain latency");
			end else begin
				check(lat[23:0], 24'h1, "offset latency");
			end
			check({23'h0, run}, 24'h1, "run during multiply");
			pexp = exp_trim(raw, off, gn, oo, go);
			rd(aotcm_pkg::ADDR_RESULT, v);
			check(v, pexp, "result");
		end
		// One-shot sequencing in single-channel and scan modes.
		for (i = 0; i < 6; i++) begin
			wr(aotcm_pkg::ADDR_CFG3, {18'h0, sq[i], 4'h0});
			wr(aotcm_pkg::ADDR_CTRL, {21'h0, sc[i], 2'h3});
			convert($random(seed), ls[i], lat, run);
			rd(aotcm_pkg::ADDR_CTRL, v);
			check(v, {21'h0, sc[i], st[i]}, "state");
			check({23'h0, run_o}, {23'h0, st[i] == 2'h3}, "run level");
		end
		// Repeated scan cycles with a timer delay between them.
		wr(aotcm_pkg::ADDR_TIMER, 24'h000002);
		wr(aotcm_pkg::ADDR_CFG3, 24'h000030);
		wr(aotcm_pkg::ADDR_CTRL, 24'h000007);
		convert($random(seed), 1'b1, lat, run);
		check({23'h0, run}, 24'h0, "pause after cycle");
		k = 0;
		while (run_o !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		check({23'h0, k >= 9 && k <= 12}, 24'h1, "timer delay");
		rd(aotcm_pkg::ADDR_CTRL, v);
		check(v, 24'h000007, "scan state");
		test_done();
	end
endmodule
`default_nettype wire
